/* File: logic/memmap_pkg.sv */
// Shared constants and types for the memory map and flash wait logic
`default_nettype none
package memmap_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 2;
    localparam int LIMIT_W = 3;
    localparam int PERI_AW = 13;
    localparam int IRAM_BYTES_DEF = 4096;
    localparam int DISP_BYTES_DEF = 512;
    localparam logic [23:0] VEC_BASE = 24'h008000;
    localparam logic [23:0] FLASH_BASE = 24'h008000;
    localparam logic [23:0] PERI_BASE = 24'h004000;
    localparam logic [23:0] PERI_END = 24'h006000;
    localparam logic [23:0] DISP_BASE = 24'h006000;
    localparam logic [23:0] IRAM_BASE = 24'h000000;
    localparam logic [15:0] UNDEF_RDATA = 16'h0000;
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_LAST = 2'h1;

    typedef enum logic [4:0] {
        RG_IRAM = 5'h01,
        RG_DISP = 5'h02,
        RG_PERI = 5'h04,
        RG_FLASH = 5'h08,
        RG_RSVD = 5'h10
    } region_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h1,
        ST_WAIT = 2'h2
    } state_t;
endpackage : memmap_pkg
`default_nettype wire

/* File: logic/word_ram.sv */
// Single-port 16-bit RAM with byte enables and registered read data
`timescale 1ns/1ps
`default_nettype none
module word_ram #(
    parameter int WORDS = 2048,
    parameter int AW = 11
) (
    input wire logic ref_clk,
    input wire logic en,
    input wire logic we,
    input wire logic [1:0] be,
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata_q
);
    initial begin
        if (WORDS < 2 || WORDS > (1 << AW)) begin
            $error("word_ram: WORDS does not fit AW");
        end
    end

    // ****************************************
    // Byte lanes
    // ****************************************
    // Each lane owns its array so that only one process writes it
    for (genvar b = 0; b < 2; b++) begin : g_lane
        logic [7:0] lane_mem [WORDS];

        always_ff @(posedge ref_clk) begin
            if (en && we && be[b]) begin
                lane_mem[addr] <= wdata[b*8 +: 8];
            end
            if (en && !we) begin
                rdata_q[b*8 +: 8] <= lane_mem[addr];
            end
        end
    end
endmodule : word_ram
`default_nettype wire

/* File: logic/memmap_ctrl.sv */
// Memory map decoder with flash read wait cycles and RAM size limit
// Behaviour
// - Vector table base fixed at flash 0x8000
// - Two-bit flash read wait selection input
// - Three-bit field limits usable internal RAM
// - Access beyond limit reads undefined value
// - Peripheral registers decoded in 0x4000 8K
// - Display RAM usable as general RAM
// - Sixteen-bit single cycle access except flash
`timescale 1ns/1ps
`default_nettype none
module memmap_ctrl #(
    parameter int IRAM_BYTES = memmap_pkg::IRAM_BYTES_DEF,
    parameter int DISP_BYTES = memmap_pkg::DISP_BYTES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic bus_req,
    input wire logic [23:0] bus_addr,
    input wire logic bus_we,
    input wire logic [1:0] bus_be,
    input wire logic [15:0] bus_wdata,
    input wire logic [1:0] flash_read_wait_sel,
    input wire logic [2:0] ram_size_limit_field,
    input wire logic [15:0] flash_rdata,
    input wire logic [15:0] periph_rdata,
    output logic bus_ready_q,
    output logic bus_ack_q,
    output logic [15:0] bus_rdata_q,
    output logic flash_rd_q,
    output logic [23:0] flash_addr_q,
    output logic periph_sel_q,
    output logic periph_we_q,
    output logic [1:0] periph_be_q,
    output logic [12:0] periph_addr_q,
    output logic [15:0] periph_wdata_q,
    output logic [23:0] vector_base_q
);
    localparam int IRAM_WORDS = IRAM_BYTES / 2;
    localparam int DISP_WORDS = DISP_BYTES / 2;
    localparam int IRAM_AW = $clog2(IRAM_WORDS);
    localparam int DISP_AW = $clog2(DISP_WORDS);
    localparam logic [23:0] IRAM_SIZE = 24'(IRAM_BYTES);
    localparam logic [23:0] DISP_END = memmap_pkg::DISP_BASE + 24'(DISP_BYTES);

    initial begin
        if ((IRAM_BYTES & (IRAM_BYTES - 1)) != 0 || IRAM_BYTES < 4
            || 24'(IRAM_BYTES) > memmap_pkg::PERI_BASE) begin
            $error("memmap_ctrl: IRAM_BYTES must be a power of two below the peripheral window");
        end
        if ((DISP_BYTES & (DISP_BYTES - 1)) != 0 || DISP_BYTES < 4
            || DISP_END > memmap_pkg::FLASH_BASE) begin
            $error("memmap_ctrl: DISP_BYTES must be a power of two below flash");
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    memmap_pkg::region_t region;
    logic [23:0] iram_lim;
    logic accept;
    logic flash_rd_acc;
    logic iram_en;
    logic disp_en;
    logic [15:0] iram_rdata;
    logic [15:0] disp_rdata;

    assign iram_lim = IRAM_SIZE >> ram_size_limit_field;

    always_comb begin
        region = memmap_pkg::RG_RSVD;
        if (bus_addr >= memmap_pkg::FLASH_BASE) begin
            region = memmap_pkg::RG_FLASH;
        end else if (bus_addr >= memmap_pkg::PERI_BASE && bus_addr < memmap_pkg::PERI_END) begin
            region = memmap_pkg::RG_PERI;
        end else if (bus_addr >= memmap_pkg::DISP_BASE && bus_addr < DISP_END) begin
            region = memmap_pkg::RG_DISP;
        end else if (bus_addr < memmap_pkg::IRAM_BASE + iram_lim) begin
            region = memmap_pkg::RG_IRAM;
        end
    end

    assign accept = bus_req && bus_ready_q;
    assign flash_rd_acc = accept && !bus_we && region == memmap_pkg::RG_FLASH;
    assign iram_en = accept && region == memmap_pkg::RG_IRAM;
    assign disp_en = accept && region == memmap_pkg::RG_DISP;

    word_ram #(.WORDS(IRAM_WORDS), .AW(IRAM_AW)) u_iram (
        .ref_clk(ref_clk),
        .en(iram_en),
        .we(bus_we),
        .be(bus_be),
        .addr(bus_addr[IRAM_AW:1]),
        .wdata(bus_wdata),
        .rdata_q(iram_rdata)
    );

    word_ram #(.WORDS(DISP_WORDS), .AW(DISP_AW)) u_disp (
        .ref_clk(ref_clk),
        .en(disp_en),
        .we(bus_we),
        .be(bus_be),
        .addr(bus_addr[DISP_AW:1]),
        .wdata(bus_wdata),
        .rdata_q(disp_rdata)
    );

    // ****************************************
    // Access stage and flash wait sequencing
    // ****************************************
    memmap_pkg::state_t st_q;
    logic [1:0] wait_cnt_q;
    logic s1_valid_q;
    memmap_pkg::region_t s1_region_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= memmap_pkg::ST_RUN;
            wait_cnt_q <= memmap_pkg::WAIT_NONE;
        end else begin
            unique case (st_q)
                memmap_pkg::ST_RUN: begin
                    if (flash_rd_acc && flash_read_wait_sel != memmap_pkg::WAIT_NONE) begin
                        st_q <= memmap_pkg::ST_WAIT;
                        wait_cnt_q <= flash_read_wait_sel;
                    end
                end
                memmap_pkg::ST_WAIT: begin
                    if (wait_cnt_q == memmap_pkg::WAIT_LAST) begin
                        st_q <= memmap_pkg::ST_RUN;
                    end
                    wait_cnt_q <= wait_cnt_q - memmap_pkg::WAIT_LAST;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ready_q <= 1'b1;
        end else if (flash_rd_acc && flash_read_wait_sel != memmap_pkg::WAIT_NONE) begin
            bus_ready_q <= 1'b0;
        end else if (st_q == memmap_pkg::ST_WAIT && wait_cnt_q == memmap_pkg::WAIT_LAST) begin
            bus_ready_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_valid_q <= 1'b0;
            s1_region_q <= memmap_pkg::RG_RSVD;
        end else if (accept) begin
            s1_valid_q <= 1'b1;
            s1_region_q <= region;
        end else if (st_q == memmap_pkg::ST_RUN) begin
            s1_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ack_q <= 1'b0;
            bus_rdata_q <= memmap_pkg::UNDEF_RDATA;
        end else begin
            bus_ack_q <= s1_valid_q && st_q == memmap_pkg::ST_RUN;
            if (s1_valid_q && st_q == memmap_pkg::ST_RUN) begin
                unique case (s1_region_q)
                    memmap_pkg::RG_IRAM: bus_rdata_q <= iram_rdata;
                    memmap_pkg::RG_DISP: bus_rdata_q <= disp_rdata;
                    memmap_pkg::RG_PERI: bus_rdata_q <= periph_rdata;
                    memmap_pkg::RG_FLASH: bus_rdata_q <= flash_rdata;
                    memmap_pkg::RG_RSVD: bus_rdata_q <= memmap_pkg::UNDEF_RDATA;
                endcase
            end
        end
    end

    // ****************************************
    // Flash and peripheral strobes
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_rd_q <= 1'b0;
            flash_addr_q <= memmap_pkg::FLASH_BASE;
        end else if (flash_rd_acc) begin
            flash_rd_q <= 1'b1;
            flash_addr_q <= bus_addr;
        end else if (st_q == memmap_pkg::ST_RUN) begin
            flash_rd_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_sel_q <= 1'b0;
            periph_we_q <= 1'b0;
            periph_be_q <= 2'h0;
            periph_addr_q <= 13'h0000;
            periph_wdata_q <= 16'h0000;
        end else begin
            periph_sel_q <= accept && region == memmap_pkg::RG_PERI;
            if (accept && region == memmap_pkg::RG_PERI) begin
                periph_we_q <= bus_we;
                periph_be_q <= bus_be;
                periph_addr_q <= bus_addr[memmap_pkg::PERI_AW-1:0];
                periph_wdata_q <= bus_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_base_q <= memmap_pkg::VEC_BASE;
        end else begin
            vector_base_q <= memmap_pkg::VEC_BASE;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_vector_fixed: assert property (##1 vector_base_q == memmap_pkg::VEC_BASE)
        else $error("vector base moved");
    a_flash_wait_one: assert property (
        flash_rd_acc && flash_read_wait_sel == 2'h1
        |=> !bus_ready_q ##1 (bus_ready_q && !bus_ack_q) ##1 bus_ack_q)
        else $error("flash wait one wrong");
    a_flash_wait_three: assert property (
        flash_rd_acc && flash_read_wait_sel == 2'h3 |=> !bus_ready_q ##1 (!bus_ack_q && !bus_ready_q) [*2]
        ##1 (bus_ready_q && !bus_ack_q) ##1 (bus_ack_q && bus_rdata_q == $past(flash_rdata)))
        else $error("flash wait three wrong");
    a_ram_limit_range: assert property (
        accept && bus_addr < memmap_pkg::PERI_BASE && bus_addr >= iram_lim |-> !iram_en)
        else $error("limited RAM still enabled");
    a_ram_limit_undef: assert property (
        accept && !bus_we && region == memmap_pkg::RG_RSVD
        |-> ##2 (bus_ack_q && bus_rdata_q == memmap_pkg::UNDEF_RDATA))
        else $error("reserved read not undefined value");
    a_peri_window: assert property (
        accept && bus_addr >= memmap_pkg::PERI_BASE && bus_addr < memmap_pkg::PERI_END
        |=> periph_sel_q && periph_addr_q == $past(bus_addr[memmap_pkg::PERI_AW-1:0]))
        else $error("peripheral window decode wrong");
    a_disp_general: assert property (
        accept && !bus_we && region == memmap_pkg::RG_DISP |-> ##2 (bus_ack_q && bus_rdata_q == $past(disp_rdata)))
        else $error("display RAM read wrong");
    a_single_cycle: assert property (
        accept && !flash_rd_acc |=> bus_ready_q ##1 bus_ack_q)
        else $error("non-flash access not single cycle");

    c_flash_wait3: cover property (flash_rd_acc && flash_read_wait_sel == 2'h3 ##5 bus_ack_q);
    c_peri_write: cover property (accept && bus_we && region == memmap_pkg::RG_PERI);
    c_limit_hit: cover property (accept && ram_size_limit_field != 3'h0 && region == memmap_pkg::RG_RSVD);
    c_back_to_back: cover property (iram_en ##1 iram_en ##1 disp_en);
endmodule : memmap_ctrl
`default_nettype wire

/* File: verification/flash_periph_model.sv */
// Behavioural flash array and peripheral register file behind the decoder
`timescale 1ns/1ps
`default_nettype none
module flash_periph_model (
    input wire logic ref_clk,
    input wire logic flash_rd_q,
    input wire logic [23:0] flash_addr_q,
    input wire logic periph_sel_q,
    input wire logic periph_we_q,
    input wire logic [1:0] periph_be_q,
    input wire logic [12:0] periph_addr_q,
    input wire logic [15:0] periph_wdata_q,
    output logic [15:0] flash_rdata,
    output logic [15:0] periph_rdata
);
    logic [15:0] regs_q [16];
    logic [15:0] noise_q = 16'h5A3C;

    // Lines not being read show a value that changes every cycle
    always_ff @(posedge ref_clk) begin
        noise_q <= noise_q + 16'h3B97;
    end

    always_ff @(posedge ref_clk) begin
        if (periph_sel_q && periph_we_q && periph_be_q[0]) begin
            regs_q[periph_addr_q[4:1]][7:0] <= periph_wdata_q[7:0];
        end
        if (periph_sel_q && periph_we_q && periph_be_q[1]) begin
            regs_q[periph_addr_q[4:1]][15:8] <= periph_wdata_q[15:8];
        end
    end

    assign flash_rdata = flash_rd_q ? (flash_addr_q[15:0] ^ 16'hA5C3) : noise_q;
    assign periph_rdata = periph_sel_q ? regs_q[periph_addr_q[4:1]] : ~noise_q;
endmodule : flash_periph_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {logic rd; logic [15:0] data; int cyc;} note_t;
    localparam int IRAM = memmap_pkg::IRAM_BYTES_DEF;
    localparam int DISP = memmap_pkg::DISP_BYTES_DEF;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic bus_req = 1'b0;
    logic [23:0] bus_addr = 24'h000000;
    logic bus_we = 1'b0;
    logic [1:0] bus_be = 2'h3;
    logic [15:0] bus_wdata = 16'h0000;
    logic [1:0] flash_read_wait_sel = 2'h0;
    logic [2:0] ram_size_limit_field = 3'h0;
    logic [15:0] flash_rdata, periph_rdata, bus_rdata_q, periph_wdata_q;
    logic bus_ready_q, bus_ack_q, flash_rd_q, periph_sel_q, periph_we_q;
    logic [1:0] periph_be_q;
    logic [12:0] periph_addr_q;
    logic [23:0] flash_addr_q, vector_base_q, a;
    note_t notes[$];
    note_t cur;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 32'h38fd9b05;
    logic [15:0] rv;

    memmap_ctrl #(.IRAM_BYTES(IRAM), .DISP_BYTES(DISP)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus_req(bus_req), .bus_addr(bus_addr), .bus_we(bus_we), .bus_be(bus_be), .bus_wdata(bus_wdata),
        .flash_read_wait_sel(flash_read_wait_sel), .ram_size_limit_field(ram_size_limit_field),
        .flash_rdata(flash_rdata), .periph_rdata(periph_rdata), .bus_ready_q(bus_ready_q),
        .bus_ack_q(bus_ack_q), .bus_rdata_q(bus_rdata_q), .flash_rd_q(flash_rd_q), .flash_addr_q(flash_addr_q),
        .periph_sel_q(periph_sel_q), .periph_we_q(periph_we_q), .periph_be_q(periph_be_q),
        .periph_addr_q(periph_addr_q), .periph_wdata_q(periph_wdata_q), .vector_base_q(vector_base_q));

    flash_periph_model far_end (.ref_clk(ref_clk), .flash_rd_q(flash_rd_q), .flash_addr_q(flash_addr_q),
        .periph_sel_q(periph_sel_q), .periph_we_q(periph_we_q), .periph_be_q(periph_be_q),
        .periph_addr_q(periph_addr_q), .periph_wdata_q(periph_wdata_q), .flash_rdata(flash_rdata),
        .periph_rdata(periph_rdata));

    // ****************************************
    // Clock, reset and watchdog
    // ****************************************
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc = cyc + 1;
    end

    initial begin
        #400000;
        fail_count++;
        results();
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic results;
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // One request held until accepted; answer expected 2 + w cycles later
    task automatic access(input logic [23:0] ad, input logic we, input logic [1:0] be, input logic [15:0] wd,
            input logic [15:0] exp, input int w);
        int n;
        bus_req <= 1'b1;
        bus_addr <= ad;
        bus_we <= we;
        bus_be <= be;
        bus_wdata <= wd;
        n = 0;
        @(negedge ref_clk);
        while (bus_ready_q !== 1'b1 && n < 50) begin
            n++;
            @(negedge ref_clk);
        end
        notes.push_back('{rd: !we, data: exp, cyc: cyc + 2 + w});
        @(posedge ref_clk);
    endtask : access

    task automatic idle(input int n);
        bus_req <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask : idle

    // ****************************************
    // Answer monitor
    // ****************************************
    always @(negedge ref_clk) begin
        if (bus_ack_q === 1'b1) begin
            if (notes.size() == 0) begin
                check(24'h1, 24'h0, "answer without request");
            end else begin
                cur = notes.pop_front();
                check(24'(cyc), 24'(cur.cyc), "answer cycle");
                if (cur.rd) begin
                    check({8'h00, bus_rdata_q}, {8'h00, cur.data}, "read data");
                end
            end
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check(vector_base_q, memmap_pkg::VEC_BASE, "vector base");
        access(24'h000010, 1'b1, 2'h3, 16'h1234, 16'h0000, 0);
        access(24'h000010, 1'b1, 2'h1, 16'hABCD, 16'h0000, 0);
        access(24'h000011, 1'b0, 2'h3, 16'h0000, 16'h12CD, 0);
        access(24'h000010, 1'b1, 2'h2, 16'h5600, 16'h0000, 0);
        access(24'h000010, 1'b0, 2'h3, 16'h0000, 16'h56CD, 0);
        access(memmap_pkg::DISP_BASE, 1'b1, 2'h3, 16'hC3A1, 16'h0000, 0);
        access(memmap_pkg::DISP_BASE + 24'(DISP - 2), 1'b1, 2'h3, 16'h7E18, 16'h0000, 0);
        access(memmap_pkg::DISP_BASE, 1'b0, 2'h3, 16'h0000, 16'hC3A1, 0);
        access(memmap_pkg::DISP_BASE + 24'(DISP - 2), 1'b0, 2'h3, 16'h0000, 16'h7E18, 0);
        access(memmap_pkg::DISP_BASE + 24'(DISP), 1'b0, 2'h3, 16'h0000, memmap_pkg::UNDEF_RDATA, 0);
        access(24'h004010, 1'b1, 2'h3, 16'hBEEF, 16'h0000, 0);
        access(24'h005FFE, 1'b1, 2'h3, 16'h7707, 16'h0000, 0);
        access(24'h004010, 1'b0, 2'h3, 16'h0000, 16'hBEEF, 0);
        access(24'h005FFE, 1'b0, 2'h3, 16'h0000, 16'h7707, 0);
        access(24'h004010, 1'b1, 2'h1, 16'h00A5, 16'h0000, 0);
        access(24'h004010, 1'b0, 2'h3, 16'h0000, 16'hBEA5, 0);
        access(24'h003FFE, 1'b0, 2'h3, 16'h0000, memmap_pkg::UNDEF_RDATA, 0);
        for (int w = 0; w < 4; w++) begin
            flash_read_wait_sel <= 2'(w);
            a = memmap_pkg::FLASH_BASE + 24'(8 * w);
            access(a, 1'b0, 2'h3, 16'h0000, a[15:0] ^ 16'hA5C3, w);
            access(a + 24'h2, 1'b0, 2'h3, 16'h0000, a[15:0] ^ 16'hA5C1, w);
            access(24'h000010, 1'b0, 2'h3, 16'h0000, 16'h56CD, 0);
        end
        // Debug not in use, top words free
        for (int f = 0; f < 8; f++) begin
            access(24'((IRAM >> f) - 2), 1'b1, 2'h3, 16'h0F00 + 16'(f), 16'h0000, 0);
        end
        for (int f = 0; f < 8; f++) begin
            idle(2);
            ram_size_limit_field <= 3'(f);
            idle(2);
            access(24'((IRAM >> f) - 2), 1'b0, 2'h3, 16'h0000, 16'h0F00 + 16'(f), 0);
            access(24'(IRAM >> f), 1'b0, 2'h3, 16'h0000, memmap_pkg::UNDEF_RDATA, 0);
        end
        idle(2);
        ram_size_limit_field <= 3'h0;
        idle(2);
        for (int i = 0; i < 6; i++) begin
            rv = 16'($random(seed));
            a = 24'h000200 | {16'h0000, rv[7:1], 1'b0};
            access(a, 1'b1, 2'h3, rv, 16'h0000, 0);
            access(a, 1'b0, 2'h3, 16'h0000, rv, 0);
        end
        idle(10);
        check(24'(notes.size()), 24'h0, "answers missing");
        results();
    end
endmodule : tb
`default_nettype wire
